/* afesd_top.sv */
// afesd_top: configuration registers and decode for the analog front end:
// input and reference multiplexers, stage enables, bypass, gains and offsets.
// assumes a register master on core_clk; analog parts sample the outputs.
// Summary of operation
// RULE1 - straight pair codes: odd positive, even negative
// RULE2 - sign bit swaps pair polarity
// RULE3 - single-ended: input n positive, input 0 negative
// RULE4 - single-ended crossed: input 0 positive, n negative
// RULE5 - reference select picks pair 1/0 or 3/2
// RULE6 - enable bits drive modulator and three stages
// RULE7 - disabled amplifier stage is bypassed
// RULE8 - stage one gain 1 or 10
// RULE9 - stage two gains 1, 2, 5, 10
// RULE10 - stage two offset sign-magnitude, 0.2 steps
// RULE11 - stage three gain is code over twelve
// RULE12 - stage three offset sign-magnitude in twelfths
// RULE13 - defaults command restores every reset value
// RULE14 - software avoids undefined stage two offsets
// RULE15 - outputs held in flops, change only on writes
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
module afesd_top
  import afesd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [afesd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [afesd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [afesd_pkg::DATA_W-1:0] reg_rdata,
  // input multiplexer selects, one-hot
  output logic [7:0] analog_input_pos_sel,
  output logic [7:0] analog_input_neg_sel,
  // reference multiplexer selects, one-hot
  output logic [3:0] reference_input_pos_sel,
  output logic [3:0] reference_input_neg_sel,
  // enables, bypass and bias
  output logic modulator_enable,
  output logic [2:0] stage_enable,
  output logic [2:0] stage_bypass,
  output logic [1:0] modulator_bias,
  output logic [1:0] amp_bias,
  // gains and offsets
  output logic [3:0] stage1_gain,
  output logic [3:0] stage2_gain,
  output logic stage2_offset_neg,
  output logic [2:0] stage2_offset_mag,
  output logic stage2_offset_undef,
  output logic [6:0] stage3_gain,
  output logic stage3_offset_neg,
  output logic [5:0] stage3_offset_mag
);
  import afesd_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [3:0] en;
    logic [1:0] amp_b;
    logic [1:0] mod_b;
    logic [1:0] s2_code;
    logic [3:0] s2_off;
    logic s1_code;
    logic [6:0] s3_code;
    logic [6:0] s3_off;
    logic [4:0] sel;
    logic ref_sel;
    logic [2:0] pos_idx;
    logic [2:0] neg_idx;
    logic [7:0] pos_sel;
    logic [7:0] neg_sel;
    logic [3:0] ref_pos;
    logic [3:0] ref_neg;
    logic [2:0] byp;
    logic [3:0] s1_gain;
    logic [3:0] s2_gain;
    logic s2_neg;
    logic [2:0] s2_mag;
    logic s2_undef;
    logic s3_neg;
    logic [5:0] s3_mag;
    logic [7:0] rdata;
  } afesd_state_t;

  // reset image, decode matches the reset configuration
  localparam afesd_state_t ST_RST = '{
    en: RST_ENABLE, amp_b: RST_AMP_BIAS, mod_b: RST_MOD_BIAS,
    pos_idx: COMMON_INPUT + 3'h1, neg_idx: COMMON_INPUT,
    pos_sel: ONE_HOT_BASE << (COMMON_INPUT + 3'h1), neg_sel: ONE_HOT_BASE << COMMON_INPUT,
    ref_pos: REF0_POS, ref_neg: REF0_NEG, byp: ~RST_ENABLE[3:1],
    s1_gain: GAIN_X1, s2_gain: GAIN_X1, default: '0
  };

  afesd_state_t r_reg; // registered state
  afesd_state_t r_next; // next state

  // write hits per register
  logic hit_en;
  logic hit_s2;
  logic hit_gain;
  logic hit_off3;
  logic hit_five;
  logic restore_defaults; // defaults command
  assign hit_en = reg_wr && (reg_addr == ADDR_CFG_ENABLE);
  assign hit_s2 = reg_wr && (reg_addr == ADDR_CFG_STAGE2);
  assign hit_gain = reg_wr && (reg_addr == ADDR_CFG_GAIN);
  assign hit_off3 = reg_wr && (reg_addr == ADDR_CFG_OFFSET3);
  assign hit_five = reg_wr && (reg_addr == ADDR_CFG_FIVE);
  // restore wins over the select and reference bits of the same word
  assign restore_defaults = hit_five && reg_wdata[RESTORE_BIT];

  // next configuration fields; defaults command overrides all [RULE13]
  logic [3:0] nx_en;
  logic [1:0] nx_amp_b;
  logic [1:0] nx_mod_b;
  logic [1:0] nx_s2_code;
  logic [3:0] nx_s2_off;
  logic nx_s1_code;
  logic [6:0] nx_s3_code;
  logic [6:0] nx_s3_off;
  logic [4:0] nx_sel;
  logic nx_ref;
  assign nx_en = restore_defaults ? RST_ENABLE : hit_en ? reg_wdata[EN_MSB:EN_LSB] : r_reg.en;
  assign nx_amp_b = restore_defaults ? RST_AMP_BIAS :
                    hit_en ? reg_wdata[AMP_BIAS_MSB:AMP_BIAS_LSB] : r_reg.amp_b;
  assign nx_mod_b = restore_defaults ? RST_MOD_BIAS :
                    hit_en ? reg_wdata[MOD_BIAS_MSB:MOD_BIAS_LSB] : r_reg.mod_b;
  assign nx_s2_code = restore_defaults ? RST_S2_GAIN :
                      hit_s2 ? reg_wdata[S2_GAIN_MSB:S2_GAIN_LSB] : r_reg.s2_code;
  assign nx_s2_off = restore_defaults ? RST_S2_OFF :
                     hit_s2 ? reg_wdata[S2_OFF_MSB:S2_OFF_LSB] : r_reg.s2_off;
  assign nx_s1_code = restore_defaults ? RST_S1_GAIN : hit_gain ? reg_wdata[S1_GAIN_BIT] : r_reg.s1_code;
  assign nx_s3_code = restore_defaults ? RST_S3_GAIN :
                      hit_gain ? reg_wdata[S3_GAIN_MSB:S3_GAIN_LSB] : r_reg.s3_code;
  assign nx_s3_off = restore_defaults ? RST_S3_OFF :
                     hit_off3 ? reg_wdata[S3_OFF_MSB:S3_OFF_LSB] : r_reg.s3_off;
  assign nx_sel = restore_defaults ? RST_SEL : hit_five ? reg_wdata[SEL_MSB:SEL_LSB] : r_reg.sel;
  assign nx_ref = restore_defaults ? RST_REF : hit_five ? reg_wdata[REF_BIT] : r_reg.ref_sel;

  // offset code splitting [RULE10] [RULE12]
  logic s2_neg_w;
  logic [2:0] s2_mag_w;
  logic s3_neg_w;
  logic [5:0] s3_mag_w;
  // zero flag left open: the sign output already folds it in
  afesd_sign_mag #(.W(4)) u_s2_off (
    .code(nx_s2_off),
    .neg(s2_neg_w),
    .mag(s2_mag_w),
    .zero()
  );
  // same split for the seven-bit third stage code
  afesd_sign_mag #(.W(7)) u_s3_off (
    .code(nx_s3_off),
    .neg(s3_neg_w),
    .mag(s3_mag_w),
    .zero()
  );

  // decode from the next configuration; it moves only on writes [RULE15]
  always_comb begin
    r_next = r_reg;
    // stored configuration
    r_next.en = nx_en;
    r_next.amp_b = nx_amp_b;
    r_next.mod_b = nx_mod_b;
    r_next.s2_code = nx_s2_code;
    r_next.s2_off = nx_s2_off;
    r_next.s1_code = nx_s1_code;
    r_next.s3_code = nx_s3_code;
    r_next.s3_off = nx_s3_off;
    r_next.sel = nx_sel;
    r_next.ref_sel = nx_ref;
    // input multiplexer by mode and sign bits
    unique case ({nx_sel[SEL_MODE], nx_sel[SEL_SIGN]})
      // straight pair [RULE1]
      2'h0: begin
        r_next.pos_idx = {nx_sel[1:0], 1'h1};
        r_next.neg_idx = {nx_sel[1:0], 1'h0};
      end
      // crossed pair [RULE2]
      2'h1: begin
        r_next.pos_idx = {nx_sel[1:0], 1'h0};
        r_next.neg_idx = {nx_sel[1:0], 1'h1};
      end
      // common input on the negative side [RULE3]
      2'h2: begin
        r_next.pos_idx = nx_sel[2:0];
        r_next.neg_idx = COMMON_INPUT;
      end
      // common input on the positive side [RULE4]
      2'h3: begin
        r_next.pos_idx = COMMON_INPUT;
        r_next.neg_idx = nx_sel[2:0];
      end
    endcase
    r_next.pos_sel = ONE_HOT_BASE << r_next.pos_idx;
    r_next.neg_sel = ONE_HOT_BASE << r_next.neg_idx;
    // reference pair [RULE5]
    r_next.ref_pos = nx_ref ? REF1_POS : REF0_POS;
    r_next.ref_neg = nx_ref ? REF1_NEG : REF0_NEG;
    // disabled stages pass straight through [RULE7]
    r_next.byp = ~nx_en[3:1];
    // stage one gain [RULE8]
    r_next.s1_gain = nx_s1_code ? GAIN_X10 : GAIN_X1;
    // stage two gain [RULE9]
    unique case (nx_s2_code)
      S2G_X1: r_next.s2_gain = GAIN_X1;
      S2G_X2: r_next.s2_gain = GAIN_X2;
      S2G_X5: r_next.s2_gain = GAIN_X5;
      S2G_X10: r_next.s2_gain = GAIN_X10;
    endcase
    // stage two offset, undefined codes flagged [RULE10]
    r_next.s2_neg = s2_neg_w;
    r_next.s2_mag = s2_mag_w;
    r_next.s2_undef = (s2_mag_w > S2_MAG_MAX) || (nx_s2_off == S2_NEG_ZERO);
    // stage three offset, negative zero is zero [RULE12]
    r_next.s3_neg = s3_neg_w;
    r_next.s3_mag = s3_mag_w;
    // read data stands one cycle only
    r_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG_ENABLE: r_next.rdata = {r_reg.mod_b, r_reg.amp_b, r_reg.en};
        ADDR_CFG_STAGE2: r_next.rdata = {2'h0, r_reg.s2_code, r_reg.s2_off};
        ADDR_CFG_GAIN: r_next.rdata = {r_reg.s1_code, r_reg.s3_code};
        ADDR_CFG_OFFSET3: r_next.rdata = {1'h0, r_reg.s3_off};
        // defaults bit reads back zero
        ADDR_CFG_FIVE: r_next.rdata = {2'h0, r_reg.sel, r_reg.ref_sel};
        // decoded state
        ADDR_STATUS: r_next.rdata = {r_reg.s2_undef, r_reg.pos_idx, 1'h0, r_reg.neg_idx};
        // unmapped reads zero
        default: r_next.rdata = '0;
      endcase
    end
  end

  // state register
  // async clear loads the reset image, decode included
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register [RULE6]
  assign reg_rdata = r_reg.rdata;
  assign analog_input_pos_sel = r_reg.pos_sel;
  assign analog_input_neg_sel = r_reg.neg_sel;
  assign reference_input_pos_sel = r_reg.ref_pos;
  assign reference_input_neg_sel = r_reg.ref_neg;
  assign modulator_enable = r_reg.en[0];
  assign stage_enable = r_reg.en[3:1];
  assign stage_bypass = r_reg.byp;
  assign modulator_bias = r_reg.mod_b;
  assign amp_bias = r_reg.amp_b;
  assign stage1_gain = r_reg.s1_gain;
  assign stage2_gain = r_reg.s2_gain;
  assign stage2_offset_neg = r_reg.s2_neg;
  assign stage2_offset_mag = r_reg.s2_mag;
  assign stage2_offset_undef = r_reg.s2_undef;
  // gain in twelfths is the code itself [RULE11]
  assign stage3_gain = r_reg.s3_code;
  assign stage3_offset_neg = r_reg.s3_neg;
  assign stage3_offset_mag = r_reg.s3_mag;

  // checks on the decode
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // plain write of the select register with given mode and sign
  sequence s_sel_wr(logic m, logic s);
    hit_five && !reg_wdata[RESTORE_BIT] && reg_wdata[SEL_LSB+SEL_MODE] == m && reg_wdata[SEL_LSB+SEL_SIGN] == s;
  endsequence
  // plain write of a configuration register
  sequence s_cfg_wr(logic hit);
    hit && !restore_defaults;
  endsequence

  // input and reference multiplexers
  a_onehot_selects: assert property ( // [RULE1] [RULE5]
    $onehot(analog_input_pos_sel) && $onehot(analog_input_neg_sel) &&
    $onehot(reference_input_pos_sel) && $onehot(reference_input_neg_sel))
    else $error("multiplexer select not one-hot");
  a_pair_straight: assert property (s_sel_wr(1'h0, 1'h0) |=> // [RULE1]
    analog_input_pos_sel == (ONE_HOT_BASE << {$past(reg_wdata[SEL_LSB+1:SEL_LSB]), 1'h1}) &&
    analog_input_neg_sel == (ONE_HOT_BASE << {$past(reg_wdata[SEL_LSB+1:SEL_LSB]), 1'h0}))
    else $error("straight pair select wrong");
  a_pair_crossed: assert property (s_sel_wr(1'h0, 1'h1) |=> // [RULE2]
    r_reg.pos_idx == {$past(reg_wdata[SEL_LSB+1:SEL_LSB]), 1'h0} &&
    r_reg.neg_idx == {$past(reg_wdata[SEL_LSB+1:SEL_LSB]), 1'h1})
    else $error("crossed pair select wrong");
  a_single_straight: assert property (s_sel_wr(1'h1, 1'h0) |=> // [RULE3]
    r_reg.pos_idx == $past(reg_wdata[SEL_LSB+2:SEL_LSB]) && analog_input_neg_sel == ONE_HOT_BASE)
    else $error("single-ended straight wrong");
  a_single_crossed: assert property (s_sel_wr(1'h1, 1'h1) |=> // [RULE4]
    analog_input_pos_sel == ONE_HOT_BASE && r_reg.neg_idx == $past(reg_wdata[SEL_LSB+2:SEL_LSB]))
    else $error("single-ended crossed wrong");
  a_ref_pair_sel: assert property (s_cfg_wr(hit_five) |=> // [RULE5]
    reference_input_pos_sel == ($past(reg_wdata[REF_BIT]) ? REF1_POS : REF0_POS) &&
    reference_input_neg_sel == ($past(reg_wdata[REF_BIT]) ? REF1_NEG : REF0_NEG))
    else $error("reference pair wrong");
  // enables and bypass
  a_bypass_follows: assert property (stage_bypass == ~stage_enable) // [RULE7]
    else $error("bypass does not mirror enable");
  a_enable_bypass: assert property (s_cfg_wr(hit_en) |=> // [RULE6] [RULE7]
    {stage_enable, modulator_enable} == $past(reg_wdata[EN_MSB:EN_LSB]) && stage_bypass == ~stage_enable)
    else $error("enable or bypass wrong");
  // gains and offsets
  a_stage1_gain: assert property (s_cfg_wr(hit_gain) |=> // [RULE8]
    stage1_gain == ($past(reg_wdata[S1_GAIN_BIT]) ? GAIN_X10 : GAIN_X1))
    else $error("stage one gain wrong");
  a_stage2_gain: assert property (s_cfg_wr(hit_s2) |=> // [RULE9]
    stage2_gain == ($past(reg_wdata[S2_GAIN_MSB:S2_GAIN_LSB]) == S2G_X1 ? GAIN_X1 :
                    $past(reg_wdata[S2_GAIN_MSB:S2_GAIN_LSB]) == S2G_X2 ? GAIN_X2 :
                    $past(reg_wdata[S2_GAIN_MSB:S2_GAIN_LSB]) == S2G_X5 ? GAIN_X5 : GAIN_X10))
    else $error("stage two gain wrong");
  a_stage2_sign: assert property (s_cfg_wr(hit_s2) |=> // [RULE10]
    stage2_offset_neg == ($past(reg_wdata[S2_OFF_MSB]) && stage2_offset_mag != '0))
    else $error("stage two offset sign wrong");
  a_stage2_offset: assert property (s_cfg_wr(hit_s2) |=> // [RULE10]
    stage2_offset_mag == $past(reg_wdata[S2_OFF_MSB-1:S2_OFF_LSB]) &&
    stage2_offset_undef == (stage2_offset_mag > S2_MAG_MAX || $past(reg_wdata[S2_OFF_MSB:S2_OFF_LSB]) == S2_NEG_ZERO))
    else $error("stage two offset wrong");
  a_stage3_gain: assert property (s_cfg_wr(hit_gain) |=> // [RULE11]
    stage3_gain == $past(reg_wdata[S3_GAIN_MSB:S3_GAIN_LSB]))
    else $error("stage three gain wrong");
  a_stage3_offset: assert property (s_cfg_wr(hit_off3) |=> // [RULE12]
    stage3_offset_mag == $past(reg_wdata[S3_OFF_MSB-1:S3_OFF_LSB]) &&
    stage3_offset_neg == ($past(reg_wdata[S3_OFF_MSB]) && stage3_offset_mag != '0))
    else $error("stage three offset wrong");
  // defaults and holding
  a_defaults_restore: assert property (restore_defaults |=> // [RULE13]
    {stage_enable, modulator_enable} == RST_ENABLE && stage_bypass == ~RST_ENABLE[3:1] &&
    modulator_bias == RST_MOD_BIAS && stage3_gain == RST_S3_GAIN && r_reg.sel == RST_SEL &&
    amp_bias == RST_AMP_BIAS && stage1_gain == GAIN_X1 && stage2_gain == GAIN_X1 &&
    stage2_offset_mag == RST_S2_OFF[S2_OFF_MSB-1:S2_OFF_LSB] && reference_input_pos_sel == REF0_POS &&
    stage3_offset_mag == RST_S3_OFF[S3_OFF_MSB-1:S3_OFF_LSB])
    else $error("defaults not restored");
  a_hold_no_write: assert property (!reg_wr |=> // [RULE15]
    $stable(analog_input_pos_sel) && $stable(stage_bypass) && $stable(stage2_gain) &&
    $stable(stage3_offset_mag) && $stable(analog_input_neg_sel) && $stable(reference_input_pos_sel) &&
    $stable(stage1_gain) && $stable(stage3_gain) && $stable(modulator_bias))
    else $error("output moved without a write");
endmodule

/* afesd_pkg.sv */
// afesd_pkg: register map, field positions, reset values and decode codes
// for the acquisition front-end select decoder.
// assumes one 8-bit register port with a 3-bit word address.
package afesd_pkg;
  // bus widths
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CFG_ENABLE = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG_STAGE2 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CFG_GAIN = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CFG_OFFSET3 = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CFG_FIVE = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h5;

  // enable register fields
  localparam int EN_LSB = 0;
  localparam int EN_MSB = 3;
  localparam int AMP_BIAS_LSB = 4;
  localparam int AMP_BIAS_MSB = 5;
  localparam int MOD_BIAS_LSB = 6;
  localparam int MOD_BIAS_MSB = 7;
  // stage2 register fields
  localparam int S2_OFF_LSB = 0;
  localparam int S2_OFF_MSB = 3;
  localparam int S2_GAIN_LSB = 4;
  localparam int S2_GAIN_MSB = 5;
  // gain register fields
  localparam int S3_GAIN_LSB = 0;
  localparam int S3_GAIN_MSB = 6;
  localparam int S1_GAIN_BIT = 7;
  // stage3 offset register field
  localparam int S3_OFF_LSB = 0;
  localparam int S3_OFF_MSB = 6;
  // cfg five fields
  localparam int REF_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 5;
  localparam int RESTORE_BIT = 6;
  // positions inside the input-select field
  localparam int SEL_MODE = 4;
  localparam int SEL_SIGN = 3;

  // configuration reset values
  localparam logic [3:0] RST_ENABLE = 4'h1;
  localparam logic [1:0] RST_AMP_BIAS = 2'h3;
  localparam logic [1:0] RST_MOD_BIAS = 2'h3;
  localparam logic [1:0] RST_S2_GAIN = 2'h0;
  localparam logic [3:0] RST_S2_OFF = 4'h0;
  localparam logic RST_S1_GAIN = 1'h0;
  localparam logic [6:0] RST_S3_GAIN = 7'h00;
  localparam logic [6:0] RST_S3_OFF = 7'h00;
  localparam logic [4:0] RST_SEL = 5'h00;
  localparam logic RST_REF = 1'h0;

  // input multiplexer constants
  localparam logic [2:0] COMMON_INPUT = 3'h0;
  localparam logic [7:0] ONE_HOT_BASE = 8'h01;
  // reference pair one-hot selects
  localparam logic [3:0] REF0_POS = 4'h2;
  localparam logic [3:0] REF0_NEG = 4'h1;
  localparam logic [3:0] REF1_POS = 4'h8;
  localparam logic [3:0] REF1_NEG = 4'h4;

  // gain values driven to the amplifiers
  localparam logic [3:0] GAIN_X1 = 4'h1;
  localparam logic [3:0] GAIN_X2 = 4'h2;
  localparam logic [3:0] GAIN_X5 = 4'h5;
  localparam logic [3:0] GAIN_X10 = 4'ha;
  // stage2 gain codes
  localparam logic [1:0] S2G_X1 = 2'h0;
  localparam logic [1:0] S2G_X2 = 2'h1;
  localparam logic [1:0] S2G_X5 = 2'h2;
  localparam logic [1:0] S2G_X10 = 2'h3;
  // stage2 offset limits
  localparam logic [2:0] S2_MAG_MAX = 3'h5;
  localparam logic [3:0] S2_NEG_ZERO = 4'h8;
endpackage

/* afesd_sign_mag.sv */
// afesd_sign_mag: splits a sign-magnitude offset code into sign and magnitude.
// assumes a purely combinational use; the caller registers the results.
`timescale 1ns/10ps
module afesd_sign_mag #(
  parameter int W = 4
) (
  // offset code, sign in the top bit
  input wire logic [W-1:0] code,
  // decoded fields
  output logic neg,
  output logic [W-2:0] mag,
  output logic zero
);
  // magnitude is the low bits
  assign mag = code[W-2:0];
  // both signs of a zero magnitude mean no offset
  assign zero = (code[W-2:0] == '0);
  // a negative zero is driven as plain zero
  assign neg = code[W-1] & ~zero;
endmodule

/* afesd_fe_model.sv */
// afesd_fe_model: behavioural far side, the analog muxes and the first two amplifier stages.
// assumes one-hot selects and binary gain values from afesd_top.
`timescale 1ns/10ps
module afesd_fe_model (
  // multiplexer selects
  input wire logic [7:0] pos_sel,
  input wire logic [7:0] neg_sel,
  // stage controls
  input wire logic [2:0] stage_enable,
  input wire logic [2:0] stage_bypass,
  input wire logic [3:0] stage1_gain,
  input wire logic [3:0] stage2_gain,
  // what the analog chain sees
  output logic [2:0] pos_idx,
  output logic [2:0] neg_idx,
  output logic [3:0] s1_eff,
  output logic [3:0] s2_eff
);
  // index of the closed switch on each side
  always_comb begin
    pos_idx = 3'h0;
    neg_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (pos_sel[i]) pos_idx = i[2:0];
      if (neg_sel[i]) neg_idx = i[2:0];
    end
  end
  // bypassed stage passes its input straight on; a clash gives 4'hf
  always_comb begin
    s1_eff = (stage_enable[0] & ~stage_bypass[0]) ? stage1_gain :
             (~stage_enable[0] & stage_bypass[0]) ? 4'h1 : 4'hf;
    s2_eff = (stage_enable[1] & ~stage_bypass[1]) ? stage2_gain :
             (~stage_enable[1] & stage_bypass[1]) ? 4'h1 : 4'hf;
  end
endmodule

/* tb.sv */
// tb: self-checking bench for afesd_top with the front-end model beside it.
// assumes 100 MHz core_clk and the register map of afesd_pkg.
`timescale 1ns/10ps
module tb;
  import afesd_pkg::*;
  // clock, reset, register port
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  // decoded outputs
  logic [7:0] analog_input_pos_sel, analog_input_neg_sel;
  logic [3:0] reference_input_pos_sel, reference_input_neg_sel;
  logic modulator_enable;
  logic [2:0] stage_enable, stage_bypass;
  logic [1:0] modulator_bias, amp_bias;
  logic [3:0] stage1_gain, stage2_gain;
  logic stage2_offset_neg, stage2_offset_undef, stage3_offset_neg;
  logic [2:0] stage2_offset_mag;
  logic [6:0] stage3_gain;
  logic [5:0] stage3_offset_mag;
  // model view
  logic [2:0] m_pos, m_neg;
  logic [3:0] m_s1, m_s2;
  int checked = 0;
  int miscompares = 0;
  // 10 ns clock
  always #5 core_clk = ~core_clk;
  afesd_top uut (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .analog_input_pos_sel, .analog_input_neg_sel, .reference_input_pos_sel, .reference_input_neg_sel,
    .modulator_enable, .stage_enable, .stage_bypass, .modulator_bias, .amp_bias, .stage1_gain,
    .stage2_gain, .stage2_offset_neg, .stage2_offset_mag, .stage2_offset_undef, .stage3_gain,
    .stage3_offset_neg, .stage3_offset_mag);
  afesd_fe_model fe (.pos_sel(analog_input_pos_sel), .neg_sel(analog_input_neg_sel),
    .stage_enable, .stage_bypass, .stage1_gain, .stage2_gain, .pos_idx(m_pos), .neg_idx(m_neg),
    .s1_eff(m_s1), .s2_eff(m_s2));
  // compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write, outputs settled on return
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // every decoded output at its reset value
  task automatic chk_defaults();
    chk("pos_sel", 8'h02, analog_input_pos_sel);
    chk("neg_sel", 8'h01, analog_input_neg_sel);
    chk("ref_pos", 8'h02, reference_input_pos_sel);
    chk("ref_neg", 8'h01, reference_input_neg_sel);
    chk("mod_en", 8'h01, modulator_enable);
    chk("stage_en", 8'h00, stage_enable);
    chk("bypass", 8'h07, stage_bypass);
    chk("biases", 8'h0f, {modulator_bias, amp_bias});
    chk("s1_gain", 8'h01, stage1_gain);
    chk("s2_gain", 8'h01, stage2_gain);
    chk("s2_off", 8'h00, {stage2_offset_undef, stage2_offset_neg, stage2_offset_mag});
    chk("s3_gain", 8'h00, stage3_gain);
    chk("s3_off", 8'h00, {stage3_offset_neg, stage3_offset_mag});
  endtask
  // all 32 input-select codes, reference bit toggled alongside
  task automatic t_select();
    logic [7:0] d;
    logic [2:0] p, n;
    for (int c = 0; c < 32; c++) begin
      if (c[4]) begin
        p = c[3] ? 3'h0 : c[2:0];
        n = c[3] ? c[2:0] : 3'h0;
      end else begin
        p = {c[1:0], ~c[3]};
        n = {c[1:0], c[3]};
      end
      wr(ADDR_CFG_FIVE, {2'h0, c[4:0], c[1]});
      chk("pos_sel", 8'h01 << p, analog_input_pos_sel);
      chk("neg_sel", 8'h01 << n, analog_input_neg_sel);
      chk("ref_pos", c[1] ? 8'h08 : 8'h02, reference_input_pos_sel);
      chk("ref_neg", c[1] ? 8'h04 : 8'h01, reference_input_neg_sel);
      chk("fe_pos", p, m_pos);
      chk("fe_neg", n, m_neg);
      rd(ADDR_STATUS, d);
      chk("status", {1'b0, p, 1'b0, n}, d);
    end
  endtask
  // every enable pattern, with gains set so bypass shows in the model
  task automatic t_enable();
    wr(ADDR_CFG_GAIN, 8'h80);
    wr(ADDR_CFG_STAGE2, 8'h30);
    for (int e = 0; e < 16; e++) begin
      wr(ADDR_CFG_ENABLE, {4'h6, e[3:0]});
      chk("mod_en", e[0], modulator_enable);
      chk("stage_en", e[3:1], stage_enable);
      chk("bypass", ~e[3:1] & 3'h7, stage_bypass);
      chk("biases", 8'h06, {modulator_bias, amp_bias});
      chk("fe_s1", e[1] ? 8'h0a : 8'h01, m_s1);
      chk("fe_s2", e[2] ? 8'h0a : 8'h01, m_s2);
    end
  endtask
  // gain and offset codes, boundaries included
  task automatic t_gain();
    logic [6:0] v [6] = '{7'h00, 7'h01, 7'h0c, 7'h3f, 7'h40, 7'h7f};
    logic [3:0] g2 [4] = '{4'h1, 4'h2, 4'h5, 4'ha};
    logic [3:0] o;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CFG_GAIN, {i[0], v[i]});
      chk("s1_gain", i[0] ? 8'h0a : 8'h01, stage1_gain);
      chk("s3_gain", v[i], stage3_gain);
      wr(ADDR_CFG_OFFSET3, {1'b0, v[i]});
      chk("s3_neg", v[i][6] && (v[i][5:0] != 6'h00), stage3_offset_neg);
      chk("s3_mag", v[i][5:0], stage3_offset_mag);
    end
    // only defined offset codes are written
    for (int i = 0; i < 11; i++) begin
      o = (i < 6) ? i[3:0] : i[3:0] + 4'h3;
      wr(ADDR_CFG_STAGE2, {2'h0, i[1:0], o});
      chk("s2_gain", g2[i[1:0]], stage2_gain);
      chk("s2_off", {1'b0, o[3] && (o[2:0] != 3'h0), o[2:0]},
          {stage2_offset_undef, stage2_offset_neg, stage2_offset_mag});
    end
  endtask
  // outputs hold through refused writes and idle cycles; read data checked after
  task automatic t_hold();
    logic [7:0] d;
    wr(ADDR_CFG_ENABLE, 8'h5b);
    for (int a = 5; a < 8; a++) wr(a[2:0], 8'h00);
    repeat (4) @(posedge core_clk);
    #1;
    chk("stage_en", 8'h05, stage_enable);
    chk("biases", 8'h05, {modulator_bias, amp_bias});
    rd(ADDR_CFG_ENABLE, d);
    chk("rd_enable", 8'h5b, d);
    @(posedge core_clk);
    #1 chk("rdata_idle", 8'h00, reg_rdata);
    rd(3'h6, d);
    chk("rd_unmapped", 8'h00, d);
  endtask
  // defaults command after every register was moved
  task automatic t_defaults();
    logic [7:0] d;
    logic [7:0] rv [5] = '{8'hf1, 8'h00, 8'h00, 8'h00, 8'h00};
    wr(ADDR_CFG_ENABLE, 8'h0f);
    wr(ADDR_CFG_STAGE2, 8'h35);
    wr(ADDR_CFG_GAIN, 8'hff);
    wr(ADDR_CFG_OFFSET3, 8'h7f);
    wr(ADDR_CFG_FIVE, 8'h3f);
    wr(ADDR_CFG_FIVE, 8'h7f);
    chk_defaults();
    for (int a = 0; a < 5; a++) begin
      rd(a[2:0], d);
      chk("rd_default", rv[a], d);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1 chk_defaults();
    t_select();
    t_enable();
    t_gain();
    t_hold();
    t_defaults();
    wrap_up();
  end
  // watchdog, well beyond the expected run
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
